// [src/smcp_monitor_port.sv]
// serial monitor command port: entry, security, break and commands
// ------------------------------------------------------------
// How it works
// - break is ten consecutive zero bits
// - on break: two high bits, then break
// - test entry: baud pin picks 1024/512
// - supply entry: divider always 1024
// - ground entry: enable clock step-up
// - supply/ground entry needs blank reset vector
// - echo every byte received in S_SEC_WAIT or S_CMD_WAIT
// - wait eleven bits; break cancels command
// - two-bit gap before echo and data
// - read data only after final echo
// - read opcode 4A, address high first
// - indexed write at last address plus one
// - indexed access wraps whole 64k space
// - run only pulses runPulse for one cycle
// - stack read returns pointer plus one
// - eight security bytes compared with FFF6-FFFD
// - bypass kept until next power-on reset
// - mismatch only clears securityOk; reads and run still execute
// - break sent after all eight bytes
// - match sets bit six at 40
// - NRZ framing, same rate both ways
// - entry pins captured at reset release
// ------------------------------------------------------------
`timescale 1ns/1ps
module smcp_monitor_port
  import smcp_pkg::*;
#(
  // arbitrary opcode values
  parameter logic [7:0] OP_WRITE = 8'h01,
  parameter logic [7:0] OP_INDEXED_READ_CMD = 8'h02,
  parameter logic [7:0] OP_STACK_POINTER_READ_CMD = 8'h03,
  parameter logic [7:0] OP_RUN = 8'h04
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic porReset,
  // entry pins and vector state
  input wire logic irqTestHigh,
  input wire logic irqSupply,
  input wire logic irqGround,
  input wire logic baudSelectPin,
  input wire logic vectorBlank,
  // monitor data pin
  input wire logic monDataIn,
  output logic monDataOut,
  output logic monDataOe,
  // memory and cpu
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWr,
  output logic memRd,
  input wire logic [7:0] memRdData,
  input wire logic [15:0] stackPtr,
  // status
  output logic monitorActive,
  output logic pllEnable,
  output logic securityOk,
  output logic runPulse
);

  // ------------------------------------------------------------
  // synchronisers and bit pacing
  // ------------------------------------------------------------
  logic [4:0] syncA, syncB;
  logic irqTstS, irqSupS, irqGndS, baudSelS, pinS;
  logic [10:0] period, divCnt, next_divCnt;
  logic bitTick, rxLine, rxValid, rxBreak, txLine, txBusy;
  logic [7:0] rxData;
  smcp_state_e state, next_state;

  always_ff @(posedge clk) begin
    syncA <= {irqTestHigh, irqSupply, irqGround, baudSelectPin, monDataIn};
    syncB <= syncA;
  end
  assign {irqTstS, irqSupS, irqGndS, baudSelS, pinS} = syncB;

  // own echo is masked so it is never taken as host traffic
  assign rxLine = monDataOe ? 1'b1 : pinS;
  assign bitTick = (divCnt == 11'(period - 11'h001));

  // restart on every state change keeps gaps whole bit periods
  always_comb begin
    next_divCnt = 11'(divCnt + 11'h001);
    if (bitTick || next_state != state) begin
      next_divCnt = 11'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divCnt <= 11'h000;
    end else begin
      divCnt <= next_divCnt;
    end
  end

  // ------------------------------------------------------------
  // line receiver and transmitter
  // ------------------------------------------------------------
  logic txStart, txBreak, next_txStart, next_txBreak;
  logic [7:0] txByte, next_txByte;

  smcp_rx u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .rxLine(rxLine),
    .period(period),
    .byteValid(rxValid),
    .byteData(rxData),
    .breakSeen(rxBreak)
  );

  smcp_tx u_tx (
    .clk(clk),
    .rst_b(rst_b),
    .bitTick(bitTick),
    .start(txStart),
    .txData(txByte),
    .txBreak(txBreak),
    .lineOut(txLine),
    .busy(txBusy)
  );

  // ------------------------------------------------------------
  // security byte store
  // ------------------------------------------------------------
  logic [7:0] secByte [0:7];
  logic [2:0] secIdx, next_secIdx;
  logic secWr;

  for (genvar i = 0; i < 8; i++) begin : g_sec
    always_ff @(posedge clk) begin
      if (secWr && secIdx == 3'(i)) begin
        secByte[i] <= rxData;
      end
    end
  end

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  smcp_kind_e kind, next_kind;
  logic [15:0] addr, next_addr, spInc;
  logic [7:0] wdata, next_wdata, opc, next_opc;
  logic [2:0] opnd, next_opnd;
  logic [3:0] waitCnt, next_wait;
  logic [1:0] ph, next_ph;
  logic retLeft, next_retLeft, secMatch, next_secMatch, secDone, next_secDone;
  logic next_secOk, next_mon, next_pll, next_run, next_memRd, next_memWr;
  logic next_oe, next_out;
  logic [15:0] next_memAddr;
  logic [7:0] next_memWrData;
  logic [10:0] next_period;

  assign spInc = 16'(stackPtr + SP_INC);

  // bytes in a whole command, opcode included
  function automatic logic [2:0] cmdLen(input logic [7:0] op);
    if (op == OP_READ) return 3'h3;
    if (op == OP_WRITE) return 3'h4;
    if (op == OP_INDEXED_WRITE_CMD) return 3'h2;
    return 3'h1;
  endfunction

  always_comb begin
    next_state = state;
    next_wait = waitCnt;
    next_ph = ph;
    next_kind = kind;
    next_txByte = txByte;
    next_txBreak = txBreak;
    next_txStart = 1'b0;
    next_addr = addr;
    next_wdata = wdata;
    next_opc = opc;
    next_opnd = opnd;
    next_retLeft = retLeft;
    next_secIdx = secIdx;
    next_secMatch = secMatch;
    next_secDone = secDone;
    next_secOk = securityOk;
    next_period = period;
    next_mon = monitorActive;
    next_pll = pllEnable;
    next_run = 1'b0;
    next_memRd = 1'b0;
    next_memWr = 1'b0;
    next_memAddr = memAddr;
    next_memWrData = memWrData;
    secWr = 1'b0;
    case (state)
      S_ENTRY: begin
        // pins are read once, in the first cycle after release
        next_state = S_OFF;
        if (irqTstS) begin
          next_mon = 1'b1;
          next_period = baudSelS ? DIV_HI : DIV_LO;
        end else if (irqSupS && vectorBlank) begin
          next_mon = 1'b1;
          next_period = DIV_HI;
        end else if (irqGndS && vectorBlank) begin
          next_mon = 1'b1;
          next_pll = 1'b1;
          next_period = DIV_HI;
        end
        if (next_mon) begin
          // bypass survives resets other than power-on
          next_state = secDone ? S_GAP : S_SEC_WAIT;
          next_kind = K_BREAK;
          next_txBreak = 1'b1;
          next_wait = 4'h0;
        end
      end
      S_SEC_WAIT: begin
        if (rxValid) begin
          secWr = 1'b1;
          next_txByte = rxData;
          next_txBreak = 1'b0;
          next_kind = K_SEC_ECHO;
          next_state = S_GAP;
          next_wait = 4'h0;
        end
      end
      S_SEC_CHK: begin
        next_ph = 2'(ph + 2'h1);
        if (ph == 2'h0) begin
          next_memRd = 1'b1;
          next_memAddr = 16'(SEC_BASE + {13'h0000, secIdx});
        end else if (ph == 2'h2) begin
          next_ph = 2'h0;
          next_secIdx = 3'(secIdx + 3'h1);
          // erased locations read as FF and are compared as such
          if (memRdData != secByte[secIdx]) begin
            next_secMatch = 1'b0;
          end
          if (secIdx == SEC_LAST) begin
            next_secDone = 1'b1;
            next_secOk = next_secMatch;
            next_kind = K_BREAK;
            next_txBreak = 1'b1;
            next_wait = 4'h0;
            next_state = next_secMatch ? S_FLAG : S_GAP;
          end
        end
      end
      S_FLAG: begin
        next_ph = 2'(ph + 2'h1);
        if (ph == 2'h0) begin
          next_memRd = 1'b1;
          next_memAddr = FLAG_ADDR;
        end else if (ph == 2'h2) begin
          next_memWr = 1'b1;
          next_memWrData = memRdData | (8'h01 << FLAG_BIT);
          next_state = S_GAP;
          next_wait = 4'h0;
        end
      end
      S_GAP: begin
        if (bitTick) begin
          next_wait = 4'(waitCnt + 4'h1);
          if (waitCnt == 4'(GAP_BITS - 4'h1)) begin
            next_state = S_TX;
            next_txStart = 1'b1;
          end
        end
      end
      S_TX: begin
        if (!txBusy && !txStart) begin
          next_wait = 4'h0;
          next_ph = 2'h0;
          case (kind)
            K_SEC_ECHO: begin
              next_state = S_SEC_WAIT;
              if (secIdx == SEC_LAST) begin
                next_state = S_SEC_CHK;
                next_secMatch = 1'b1;
              end
              next_secIdx = 3'(secIdx + 3'h1);
            end
            K_ECHO: begin
              // full command echoed: hold off before acting
              next_state = (opnd == cmdLen(opc)) ? S_DELAY : S_CMD_WAIT;
            end
            K_DATA: begin
              next_state = S_CMD_WAIT;
              if (retLeft) begin
                next_retLeft = 1'b0;
                next_txByte = spInc[7:0];
                next_state = S_GAP;
              end
            end
            default: begin
              next_state = S_CMD_WAIT;
              next_opnd = 3'h0;
            end
          endcase
        end
      end
      S_BRK_HI: begin
        if (bitTick) begin
          next_wait = 4'(waitCnt + 4'h1);
          if (waitCnt == 4'(BRK_HIGH_BITS - 4'h1)) begin
            next_state = S_TX;
            next_txStart = 1'b1;
            next_txBreak = 1'b1;
            next_kind = K_BREAK;
          end
        end
      end
      S_CMD_WAIT: begin
        if (rxBreak) begin
          next_state = S_BRK_HI;
          next_wait = 4'h0;
        end else if (rxValid) begin
          next_opnd = 3'(opnd + 3'h1);
          if (opnd == 3'h0) begin
            next_opc = rxData;
          end else if (opc == OP_INDEXED_WRITE_CMD || opnd == 3'h3) begin
            next_wdata = rxData;
          end else if (opnd == 3'h1) begin
            next_addr = {rxData, addr[7:0]};
          end else begin
            next_addr = {addr[15:8], rxData};
          end
          next_txByte = rxData;
          next_txBreak = 1'b0;
          next_kind = K_ECHO;
          next_state = S_GAP;
          next_wait = 4'h0;
        end
      end
      S_DELAY: begin
        if (rxBreak) begin
          next_state = S_BRK_HI;
          next_wait = 4'h0;
          next_opnd = 3'h0;
        end else if (bitTick) begin
          next_wait = 4'(waitCnt + 4'h1);
          if (waitCnt == 4'(DELAY_BITS - 4'h1)) begin
            next_state = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        next_opnd = 3'h0;
        next_state = S_CMD_WAIT;
        next_memAddr = addr;
        next_memWrData = wdata;
        next_ph = 2'h0;
        next_wait = 4'h0;
        if (opc == OP_INDEXED_READ_CMD || opc == OP_INDEXED_WRITE_CMD) begin
          next_addr = 16'(addr + 16'h0001);
          next_memAddr = next_addr;
        end
        if (opc == OP_READ || opc == OP_INDEXED_READ_CMD) begin
          next_memRd = 1'b1;
          next_state = S_DATA_WAIT;
        end else if (opc == OP_WRITE || opc == OP_INDEXED_WRITE_CMD) begin
          next_memWr = 1'b1;
        end else if (opc == OP_STACK_POINTER_READ_CMD) begin
          next_txByte = spInc[15:8];
          next_retLeft = 1'b1;
          next_kind = K_DATA;
          next_txBreak = 1'b0;
          next_state = S_GAP;
        end else if (opc == OP_RUN) begin
          next_run = 1'b1;
        end
      end
      S_DATA_WAIT: begin
        next_ph = 2'(ph + 2'h1);
        if (ph == 2'h1) begin
          next_txByte = memRdData;
          next_txBreak = 1'b0;
          next_kind = K_DATA;
          next_state = S_GAP;
        end
      end
      S_OFF: next_state = S_OFF;
      default: next_state = S_ENTRY;
    endcase
    // only a power-on reset forgets the bypass
    if (!rst_b && porReset) begin
      next_secOk = 1'b0;
      next_secDone = 1'b0;
    end
    next_oe = (state == S_BRK_HI) || (state == S_TX);
    next_out = (state == S_BRK_HI) ? 1'b1 : txLine;
  end

  always_ff @(posedge clk) begin
    securityOk <= next_secOk;
    secDone <= next_secDone;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= S_ENTRY;
      waitCnt <= 4'h0;
      ph <= 2'h0;
      kind <= K_BREAK;
      txByte <= 8'h00;
      txBreak <= 1'b0;
      txStart <= 1'b0;
      addr <= 16'h0000;
      wdata <= 8'h00;
      opc <= 8'h00;
      opnd <= 3'h0;
      retLeft <= 1'b0;
      secIdx <= 3'h0;
      secMatch <= 1'b0;
      period <= DIV_HI;
      monitorActive <= 1'b0;
      pllEnable <= 1'b0;
      runPulse <= 1'b0;
      memRd <= 1'b0;
      memWr <= 1'b0;
      memAddr <= 16'h0000;
      memWrData <= 8'h00;
      monDataOe <= 1'b0;
      monDataOut <= 1'b1;
    end else begin
      state <= next_state;
      waitCnt <= next_wait;
      ph <= next_ph;
      kind <= next_kind;
      txByte <= next_txByte;
      txBreak <= next_txBreak;
      txStart <= next_txStart;
      addr <= next_addr;
      wdata <= next_wdata;
      opc <= next_opc;
      opnd <= next_opnd;
      retLeft <= next_retLeft;
      secIdx <= next_secIdx;
      secMatch <= next_secMatch;
      period <= next_period;
      monitorActive <= next_mon;
      pllEnable <= next_pll;
      runPulse <= next_run;
      memRd <= next_memRd;
      memWr <= next_memWr;
      memAddr <= next_memAddr;
      memWrData <= next_memWrData;
      monDataOe <= next_oe;
      monDataOut <= next_out;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_break_high: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_BRK_HI |=> monDataOe && monDataOut)
    else $error("line not driven high before break reply");
  a_div_test: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_ENTRY && irqTstS |=> period == ($past(baudSelS) ? DIV_HI : DIV_LO))
    else $error("wrong divider at test entry");
  a_div_supply: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_ENTRY && !irqTstS && irqSupS && vectorBlank |=> period == DIV_HI)
    else $error("supply entry divider not 1024");
  a_pll_ground: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_ENTRY && !irqTstS && !irqSupS && irqGndS && vectorBlank |=> pllEnable)
    else $error("step-up clock not enabled");
  a_entry_blank: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_ENTRY && !irqTstS && !vectorBlank |=> !monitorActive)
    else $error("entry allowed with programmed vector");
  a_echo_byte: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_CMD_WAIT && rxValid && !rxBreak |=> txByte == $past(rxData) && state == S_GAP)
    else $error("received byte not queued for echo");
  a_cancel_cmd: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_DELAY && rxBreak |=> state == S_BRK_HI ##1 !memWr && !memRd)
    else $error("break did not cancel command");
  a_gap_first: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state == S_TX) && kind != K_BREAK |-> $past(state == S_GAP) && $past(bitTick))
    else $error("echo or data sent without gap");
  a_read_addr: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_EXEC && opc == OP_READ |=> memRd && memAddr == $past(addr))
    else $error("read issued at wrong address");
  a_indexed_write_cmd_addr: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_EXEC && opc == OP_INDEXED_WRITE_CMD |=> memWr && memAddr == 16'($past(addr) + 16'h0001))
    else $error("indexed write not at next address");
  a_flag_write: assert property (@(posedge clk) disable iff (!rst_b)
    memWr && state != S_CMD_WAIT |-> memAddr == FLAG_ADDR && memWrData[FLAG_BIT] && securityOk)
    else $error("security flag write wrong");

endmodule

// [src/smcp_pkg.sv]
// shared constants and types of the serial monitor command port
package smcp_pkg;

  // ------------------------------------------------------------
  // bit timing, in clock cycles per bit and in bit periods
  // ------------------------------------------------------------
  localparam logic [10:0] DIV_HI = 11'h400;
  localparam logic [10:0] DIV_LO = 11'h200;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] GAP_BITS = 4'h2;
  localparam logic [3:0] BRK_HIGH_BITS = 4'h2;
  localparam logic [3:0] DELAY_BITS = 4'hB;

  // ------------------------------------------------------------
  // clock step-up at ground entry
  // ------------------------------------------------------------
  localparam int PLL_REF_HZ = 32768;
  localparam int PLL_OUT_HZ = 2457600;
  localparam int PLL_MULT = PLL_OUT_HZ / PLL_REF_HZ;

  // ------------------------------------------------------------
  // addresses and fields
  // ------------------------------------------------------------
  localparam logic [15:0] SEC_BASE = 16'hFFF6;
  localparam logic [2:0] SEC_LAST = 3'h7;
  localparam logic [15:0] FLAG_ADDR = 16'h0040;
  localparam int FLAG_BIT = 6;
  localparam logic [15:0] SP_INC = 16'h0001;

  // ------------------------------------------------------------
  // opcodes with printed values
  // ------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h4A;
  localparam logic [7:0] OP_INDEXED_WRITE_CMD = 8'h19;

  // ------------------------------------------------------------
  // states and kinds of transmitted frame
  // ------------------------------------------------------------
  typedef enum logic [11:0] {
    S_ENTRY = 12'h001,
    S_OFF = 12'h002,
    S_SEC_WAIT = 12'h004,
    S_SEC_CHK = 12'h008,
    S_FLAG = 12'h010,
    S_GAP = 12'h020,
    S_TX = 12'h040,
    S_BRK_HI = 12'h080,
    S_CMD_WAIT = 12'h100,
    S_DELAY = 12'h200,
    S_EXEC = 12'h400,
    S_DATA_WAIT = 12'h800
  } smcp_state_e;

  typedef enum logic [3:0] {
    K_SEC_ECHO = 4'h1,
    K_BREAK = 4'h2,
    K_ECHO = 4'h4,
    K_DATA = 4'h8
  } smcp_kind_e;

endpackage

// [src/smcp_rx.sv]
// receiver of one byte frame or a break on the monitor line
`timescale 1ns/1ps
module smcp_rx
  import smcp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // line and bit period
  input wire logic rxLine,
  input wire logic [10:0] period,
  // results
  output logic byteValid,
  output logic [7:0] byteData,
  output logic breakSeen
);

  logic busy, waitHigh, next_busy, next_waitHigh, next_valid, next_brk;
  logic [10:0] cnt, next_cnt;
  logic [3:0] bitIdx, next_bitIdx;
  logic [9:0] shreg, next_shreg;

  always_comb begin
    next_busy = busy;
    next_waitHigh = waitHigh;
    next_cnt = cnt;
    next_bitIdx = bitIdx;
    next_shreg = shreg;
    next_valid = 1'b0;
    next_brk = 1'b0;
    if (waitHigh) begin
      next_waitHigh = !rxLine;
    end else if (!busy) begin
      if (!rxLine) begin
        next_busy = 1'b1;
        next_cnt = {1'b0, period[10:1]};
        next_bitIdx = 4'h0;
      end
    end else if (cnt != 11'h000) begin
      next_cnt = 11'(cnt - 11'h001);
    end else begin
      next_cnt = 11'(period - 11'h001);
      next_shreg = {rxLine, shreg[9:1]};
      next_bitIdx = 4'(bitIdx + 4'h1);
      // false start: line back high at mid start bit
      if (bitIdx == 4'h0 && rxLine) begin
        next_busy = 1'b0;
      end else if (bitIdx == 4'(FRAME_BITS - 4'h1)) begin
        next_busy = 1'b0;
        if (rxLine) begin
          next_valid = 1'b1;
        end else if (shreg[9:2] == 8'h00) begin
          next_brk = 1'b1;
          next_waitHigh = 1'b1;
        end else begin
          next_waitHigh = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      waitHigh <= 1'b0;
      cnt <= 11'h000;
      bitIdx <= 4'h0;
      shreg <= 10'h3FF;
      byteValid <= 1'b0;
      breakSeen <= 1'b0;
    end else begin
      busy <= next_busy;
      waitHigh <= next_waitHigh;
      cnt <= next_cnt;
      bitIdx <= next_bitIdx;
      shreg <= next_shreg;
      byteValid <= next_valid;
      breakSeen <= next_brk;
    end
  end

  // lsb first: after the stop shift, data sits between start and stop
  assign byteData = shreg[8:1];

endmodule

// [src/smcp_tx.sv]
// transmitter of one byte frame or a break, paced by bit ticks
`timescale 1ns/1ps
module smcp_tx
  import smcp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pacing and request
  input wire logic bitTick,
  input wire logic start,
  input wire logic [7:0] txData,
  input wire logic txBreak,
  // line
  output logic lineOut,
  output logic busy
);

  logic next_busy;
  logic [9:0] shreg, next_shreg;
  logic [3:0] left, next_left;

  always_comb begin
    next_busy = busy;
    next_shreg = shreg;
    next_left = left;
    if (start) begin
      next_busy = 1'b1;
      next_left = FRAME_BITS;
      // break is ten zeros, a byte is start, lsb first, stop
      next_shreg = txBreak ? 10'h000 : {1'b1, txData, 1'b0};
    end else if (busy && bitTick) begin
      next_shreg = {1'b1, shreg[9:1]};
      next_left = 4'(left - 4'h1);
      next_busy = (left != 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      shreg <= 10'h3FF;
      left <= 4'h0;
    end else begin
      busy <= next_busy;
      shreg <= next_shreg;
      left <= next_left;
    end
  end

  assign lineOut = busy ? shreg[0] : 1'b1;

endmodule

// [tb/smcp_host_model.sv]
// host model that sends and receives frames on the monitor data pin
`timescale 1ns/1ps
module smcp_host_model #(
  parameter int P = 512
) (
  // clock
  input wire logic clk,
  // resolved pin level and host pull-down
  input wire logic pin,
  output logic hostLow
);
  initial hostLow = 1'b0;

  // start, eight bits lsb first, stop; same rate both ways
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) #1 hostLow = ~f[i];
      repeat (P - 1) @(posedge clk);
    end
  endtask

  // ten zero samples make a break
  task automatic recv(output logic [7:0] b, output logic brk);
    logic [9:0] f;
    while (pin !== 1'b0) @(posedge clk);
    repeat (P / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      f[i] = pin;
      if (i < 9) repeat (P) @(posedge clk);
    end
    b = f[8:1];
    brk = (f == 10'h000);
    // last sample is mid stop: idle one whole bit after the echo ends
    while (pin !== 1'b1) @(posedge clk);
    repeat (P + P / 2) @(posedge clk);
  endtask

  // ten zero bit periods, then release to the pull-up
  task automatic sendBrk();
    @(posedge clk) #1 hostLow = 1'b1;
    repeat (10 * P - 1) @(posedge clk);
    @(posedge clk) #1 hostLow = 1'b0;
  endtask
endmodule

// [tb/test_serial_monitor_command_port.sv]
// bench: security entry, read and indexed write over the monitor pin
`timescale 1ns/1ps
module test_serial_monitor_command_port;
  import smcp_pkg::*;
  logic clk, rst_b, porReset, monDataOut, monDataOe, memWr, memRd;
  logic monitorActive, pllEnable, securityOk, runPulse, hostLow, pin, k;
  logic baudSel = 1'b0;
  logic vecBlank = 1'b0;
  logic [7:0] nRun = 8'h00;
  localparam logic [7:0] OP_SP = 8'h03;
  localparam logic [7:0] OP_GO = 8'h04;
  logic [15:0] memAddr, stackPtr;
  logic [7:0] memWrData, memRdData, r;
  logic [7:0] mem [0:65535];
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;

  // pull-up holds the pin high when nobody drives it
  assign pin = monDataOe ? monDataOut : ~hostLow;

  smcp_monitor_port #(.OP_STACK_POINTER_READ_CMD(OP_SP), .OP_RUN(OP_GO)) i_dut (.clk(clk), .rst_b(rst_b),
    .porReset(porReset), .irqTestHigh(1'b1), .irqSupply(1'b0), .irqGround(1'b0),
    .baudSelectPin(baudSel), .vectorBlank(vecBlank), .monDataIn(pin),
    .monDataOut(monDataOut), .monDataOe(monDataOe), .memAddr(memAddr), .memWrData(memWrData),
    .memWr(memWr), .memRd(memRd), .memRdData(memRdData), .stackPtr(stackPtr),
    .monitorActive(monitorActive), .pllEnable(pllEnable),
    .securityOk(securityOk), .runPulse(runPulse));

  smcp_host_model #(.P(512)) i_host (.clk(clk), .pin(pin), .hostLow(hostLow));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // memory answers the cycle after a read strobe
  always @(posedge clk) begin
    if (memRd) memRdData <= mem[memAddr];
    if (memWr) mem[memAddr] <= memWrData;
    if (runPulse === 1'b1) nRun <= 8'(nRun + 8'h01);
    cyc++;
    if (cyc == 400000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] b);
    logic [7:0] e;
    logic eb;
    i_host.send(b);
    i_host.recv(e, eb);
    chk({eb, e}, {1'b0, b});
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    porReset = 1'b1;
    stackPtr = 16'h00F0;
    mem[16'h0040] = 8'h00;
    mem[16'h1236] = 8'h00;
    mem[16'h1234] = 8'h5C;
    for (int i = 0; i < 8; i++) mem[16'hFFF6 + i] = 8'hA0 + 8'(i);
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    porReset = 1'b0;
    repeat (4) @(posedge clk);
    chk({8'h00, monitorActive}, 9'h001);
    for (int i = 0; i < 8; i++) xfer(8'hA0 + 8'(i));
    i_host.recv(r, k);
    chk({k, 8'h00}, 9'h100);
    chk({8'h00, securityOk}, 9'h001);
    chk({8'h00, mem[16'h0040][6]}, 9'h001);
    xfer(OP_READ);
    xfer(8'h12);
    xfer(8'h34);
    i_host.recv(r, k);
    chk({k, r}, 9'h05C);
    xfer(OP_INDEXED_WRITE_CMD);
    xfer(8'h3E);
    // eleven bit delay before the write lands
    repeat (6000) @(posedge clk);
    chk({1'b0, mem[16'h1235]}, 9'h03E);
    // break inside the delay cancels this write
    xfer(OP_INDEXED_WRITE_CMD);
    xfer(8'h77);
    i_host.sendBrk();
    i_host.recv(r, k);
    chk({k, 8'h00}, 9'h100);
    chk({1'b0, mem[16'h1236]}, 9'h000);
    xfer(OP_SP);
    i_host.recv(r, k);
    chk({k, r}, 9'h000);
    i_host.recv(r, k);
    chk({k, r}, 9'h0F1);
    xfer(OP_GO);
    repeat (6000) @(posedge clk);
    chk({1'b0, nRun}, 9'h001);
    // warm reset keeps the bypass: break comes without security bytes
    #1 rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    i_host.recv(r, k);
    chk({k, 8'h00}, 9'h100);
    chk({8'h00, securityOk}, 9'h001);
    chk({8'h00, pllEnable}, 9'h000);
    wrap_up();
  end
endmodule
